/* File: logic/adcs_clkdiv.v */
// conversion clock tick generator: oscillator divider or rc clock
// assumes clk_i is the system oscillator; rc_clk_i is asynchronous
`timescale 1ns/1ps
`include "adcs_regs.vh"

module adcs_clkdiv (
    input wire clk_i,         // system clock
    input wire reset_i,       // async reset, active high
    input wire [2:0] sel_i,   // {high select bit, low select bits}
    input wire run_i,         // conversion in progress
    input wire sleep_i,       // device asleep, oscillator stopped
    input wire rc_clk_i,      // internal rc oscillator, async
    output reg tad_tick_o     // one pulse per conversion clock period
);

    reg [6:0] cnt_q;
    reg [6:0] div;
    reg rc_s1_q;
    reg rc_s2_q;
    reg rc_s3_q;
    wire use_rc;
    wire rc_edge;

    // divisor from the three bit select
    always @*
    begin
        case (sel_i)
            3'b000: div = `ADCS_DIV_2;
            3'b001: div = `ADCS_DIV_8;
            3'b010: div = `ADCS_DIV_32;
            3'b100: div = `ADCS_DIV_4;
            3'b101: div = `ADCS_DIV_16;
            3'b110: div = `ADCS_DIV_64;
            default: div = `ADCS_DIV_2;
        endcase
    end

    assign use_rc = (sel_i[1:0] == `ADCS_CLK_RC);
    assign rc_edge = rc_s2_q & ~rc_s3_q;

    // rc clock synchroniser; edge seen only past the second stage
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
        end
        else
        begin
            rc_s1_q <= rc_clk_i;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
        end
    end

    // divider restarts with each conversion so periods are whole
    // clock source select
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cnt_q <= 7'd0;
            tad_tick_o <= 1'b0;
        end
        else if (!run_i)
        begin
            cnt_q <= 7'd0;
            tad_tick_o <= 1'b0;
        end
        else if (use_rc)
        begin
            cnt_q <= 7'd0;
            tad_tick_o <= rc_edge;
        end
        else if (sleep_i)
        begin
            tad_tick_o <= 1'b0;
        end
        else if (cnt_q == div - 7'd1)
        begin
            cnt_q <= 7'd0;
            tad_tick_o <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 7'd1;
            tad_tick_o <= 1'b0;
        end
    end

endmodule

/* File: logic/adcs_regs.vh */
// register offsets, field positions, reset values and timing counts
// for the converter control sequencer; definitions only
`ifndef ADCS_REGS_VH
`define ADCS_REGS_VH

// ****************************************************************
// register byte offsets on the apb bus
// ****************************************************************
`define ADCS_OFF_CTL_MAIN 8'h00
`define ADCS_OFF_PORT_CFG 8'h04
`define ADCS_OFF_RES_HIGH 8'h08
`define ADCS_OFF_RES_LOW 8'h0c
`define ADCS_OFF_STATUS 8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define ADCS_CTL_CLK_LO_HI 7
`define ADCS_CTL_CLK_LO_LO 6
`define ADCS_CTL_CHAN_HI 5
`define ADCS_CTL_CHAN_LO 3
`define ADCS_CTL_GO 2
`define ADCS_CTL_PON 0
`define ADCS_CFG_FMT 7
`define ADCS_CFG_CLK_HI 6
`define ADCS_CFG_PCFG_HI 3
`define ADCS_CFG_PCFG_LO 0
`define ADCS_STS_FLAG 0
`define ADCS_STS_BUSY 1

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define ADCS_CTL_RESET 8'h00
`define ADCS_CFG_RESET 8'h00
`define ADCS_CTL_WMASK 8'hf9
`define ADCS_CFG_WMASK 8'hcf

// ****************************************************************
// conversion clock divisors in system clocks, and timing
// ****************************************************************
`define ADCS_DIV_2 7'd2
`define ADCS_DIV_4 7'd4
`define ADCS_DIV_8 7'd8
`define ADCS_DIV_16 7'd16
`define ADCS_DIV_32 7'd32
`define ADCS_DIV_64 7'd64
`define ADCS_CLK_RC 2'b11
`define ADCS_TAD_PER_CONV 4'd12

`endif

/* File: logic/adcs_sar.v */
// successive approximation engine, twelve conversion clocks per result
// assumes cmp_i is the asynchronous comparator output of the core
`timescale 1ns/1ps
`include "adcs_regs.vh"

module adcs_sar #(
    parameter WIDTH = 10          // result width
) (
    input wire clk_i,              // system clock
    input wire reset_i,            // async reset, active high
    input wire start_i,            // begin a conversion, one pulse
    input wire abort_i,            // stop at once, level
    input wire tad_tick_i,         // conversion clock tick
    input wire cmp_i,              // input at or above trial level, async
    output reg busy_o,             // conversion in progress
    output reg [WIDTH-1:0] code_o, // trial code to dac, final result
    output reg done_o              // result valid, one pulse
);

    reg [3:0] cnt_q;
    reg [WIDTH-1:0] bit_q;
    reg cmp_s1_q;
    reg cmp_s2_q;

    // comparator synchroniser
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end
        else
        begin
            cmp_s1_q <= cmp_i;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // first tick seeds the msb trial, one decision per tick, last tick ends
    // successive approximation
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            busy_o <= 1'b0;
            cnt_q <= 4'd0;
            bit_q <= {WIDTH{1'b0}};
            code_o <= {WIDTH{1'b0}};
            done_o <= 1'b0;
        end
        else if (abort_i)
        begin
            busy_o <= 1'b0;
            cnt_q <= 4'd0;
            done_o <= 1'b0;
        end
        else if (start_i && !busy_o)
        begin
            busy_o <= 1'b1;
            cnt_q <= 4'd0;
            bit_q <= {WIDTH{1'b0}};
            code_o <= {WIDTH{1'b0}};
            done_o <= 1'b0;
        end
        else if (busy_o && tad_tick_i)
        begin
            cnt_q <= cnt_q + 4'd1;
            if (cnt_q == 4'd0)
            begin
                bit_q <= {1'b1, {(WIDTH-1){1'b0}}};
                code_o <= {1'b1, {(WIDTH-1){1'b0}}};
            end
            else if (cnt_q == `ADCS_TAD_PER_CONV - 4'd1)
            begin
                busy_o <= 1'b0;
                done_o <= 1'b1;
            end
            else
            begin
                bit_q <= bit_q >> 1;
                code_o <= (cmp_s2_q ? code_o : (code_o & ~bit_q)) | (bit_q >> 1);
            end
        end
        else
        begin
            done_o <= 1'b0;
        end
    end

endmodule

/* File: logic/adcs_top.v */
// converter control sequencer: apb registers, pin setup, conversion control
// assumes an apb master on clk_i; sleep_i comes from the core on clk_i;
// rc_clk_i and cmp_i come from the analog side and are synchronised below
//
// Functional notes
// - three bit select picks divider or rc
// - channel field routes input zero to seven
// - go bit starts, reads one while busy
// - completion loads result, clears go, flags
// - power bit enables converter core
// - unimplemented bits read zero, ignore writes
// - format one right justifies result
// - format zero left justifies result
// - port code sets analog pin mask
// - some codes take positive reference externally
// - some codes take both references externally
// - reset forces all shared pins analog
// - reset clears control and status registers, aborts conversion
// - sleep conversion only on rc clock
// - ten bit successive approximation result
// - twelve conversion clocks per result
// - hold capacitor disconnects at start
// - result registers keep value over reset
`timescale 1ns/1ps
`include "adcs_regs.vh"

module adcs_top #(
    parameter RES_W = 10              // converter resolution
) (
    input wire clk_i,                 // system clock, 200 mhz
    input wire reset_i,               // async reset, active high
    input wire psel_i,                // apb select
    input wire penable_i,             // apb enable
    input wire pwrite_i,              // apb direction, 1 = write
    input wire [7:0] paddr_i,         // apb byte address
    input wire [31:0] pwdata_i,       // apb write data
    output wire [31:0] prdata_o,      // apb read data
    output wire pready_o,             // apb ready
    output wire pslverr_o,            // apb error, unmapped address
    input wire sleep_i,               // device in sleep mode
    input wire rc_clk_i,              // internal rc oscillator
    input wire cmp_i,                 // comparator from analog core
    output wire power_on_o,           // converter core powered
    output wire [2:0] chan_sel_o,     // selected analog input
    output wire hold_connect_o,       // hold capacitor on input pin
    output wire [RES_W-1:0] dac_code_o, // trial code to converter core
    output reg [7:0] analog_pin_o,    // 1 = pin in analog mode
    output reg vref_pos_ext_o,        // positive reference from input 3
    output reg vref_neg_ext_o,        // negative reference from input 2
    output wire conv_busy_o,          // conversion in progress
    output wire conv_flag_o           // conversion complete flag
);

    // ****************************************************************
    // state
    // ****************************************************************
    reg [7:0] ctl_q;
    reg [7:0] cfg_q;
    reg flag_q;
    reg [RES_W-1:0] result_q;
    reg [31:0] prdata_q;
    reg pslverr_q;
    reg [31:0] rd_word;
    reg rd_hit;
    reg [7:0] res_high;
    reg [7:0] res_low;
    wire setup;
    wire wr_en;
    wire wr_ctl;
    wire wr_cfg;
    wire wr_sts;
    wire start;
    wire abort;
    wire busy;
    wire done;
    wire tad_tick;
    wire [2:0] clk_sel;
    wire [3:0] pcfg;

    // ****************************************************************
    // apb slave
    // ****************************************************************

    // read data latched in setup so the access phase answers at once
    assign setup = psel_i & ~penable_i;
    assign wr_en = psel_i & penable_i & pwrite_i;
    assign wr_ctl = wr_en & (paddr_i == `ADCS_OFF_CTL_MAIN);
    assign wr_cfg = wr_en & (paddr_i == `ADCS_OFF_PORT_CFG);
    assign wr_sts = wr_en & (paddr_i == `ADCS_OFF_STATUS);
    assign pready_o = 1'b1;
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q & psel_i & penable_i;

    // result justification applied on read, stored value is raw
    // right or left justified view
    always @*
    begin
        if (cfg_q[`ADCS_CFG_FMT])
        begin
            res_high = {6'h00, result_q[9:8]};
            res_low = result_q[7:0];
        end
        else
        begin
            res_high = result_q[9:2];
            res_low = {result_q[1:0], 6'h00};
        end
    end

    // read mux; unimplemented bits come back zero
    // masked readback
    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr_i)
            `ADCS_OFF_CTL_MAIN:
                rd_word = {24'h00_0000, ctl_q[7:3], busy, 1'b0, ctl_q[0]};
            `ADCS_OFF_PORT_CFG:
                rd_word = {24'h00_0000, cfg_q & `ADCS_CFG_WMASK};
            `ADCS_OFF_RES_HIGH:
                rd_word = {24'h00_0000, res_high};
            `ADCS_OFF_RES_LOW:
                rd_word = {24'h00_0000, res_low};
            `ADCS_OFF_STATUS:
                rd_word = {30'h0000_0000, busy, flag_q};
            default:
                rd_hit = 1'b0;
        endcase
    end

    // read data and error captured at the setup edge
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata_q <= pwrite_i ? 32'h0000_0000 : rd_word;
            pslverr_q <= ~rd_hit;
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************

    // go is not stored here; it is the engine's busy state
    // reset returns registers to zero
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ctl_q <= `ADCS_CTL_RESET;
            cfg_q <= `ADCS_CFG_RESET;
        end
        else
        begin
            if (wr_ctl)
            begin
                ctl_q <= pwdata_i[7:0] & `ADCS_CTL_WMASK & 8'hfb;
            end
            if (wr_cfg)
            begin
                cfg_q <= pwdata_i[7:0] & `ADCS_CFG_WMASK;
            end
        end
    end

    // completion flag, write one clears, a new completion wins
    // set flag on completion
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            flag_q <= 1'b0;
        end
        else if (done)
        begin
            flag_q <= 1'b1;
        end
        else if (wr_sts && pwdata_i[`ADCS_STS_FLAG])
        begin
            flag_q <= 1'b0;
        end
    end

    // result has no reset on purpose, so it survives a device reset
    // result untouched by reset
    always @(posedge clk_i)
    begin
        if (done)
        begin
            result_q <= dac_code_o;
        end
    end

    // ****************************************************************
    // conversion control
    // ****************************************************************

    // the new power bit of the same write must be set for a start
    // write one to go starts
    assign start = wr_ctl & pwdata_i[`ADCS_CTL_GO] & pwdata_i[`ADCS_CTL_PON];

    // power-off aborts a running conversion
    // power bit gates the core
    assign abort = wr_ctl ? ~pwdata_i[`ADCS_CTL_PON] : ~ctl_q[`ADCS_CTL_PON];

    assign clk_sel = {cfg_q[`ADCS_CFG_CLK_HI], ctl_q[`ADCS_CTL_CLK_LO_HI:`ADCS_CTL_CLK_LO_LO]};
    assign power_on_o = ctl_q[`ADCS_CTL_PON];
    assign chan_sel_o = ctl_q[`ADCS_CTL_CHAN_HI:`ADCS_CTL_CHAN_LO];
    assign hold_connect_o = ctl_q[`ADCS_CTL_PON] & ~busy;
    assign conv_busy_o = busy;
    assign conv_flag_o = flag_q;

    adcs_clkdiv u_clkdiv (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .sel_i(clk_sel),
        .run_i(busy),
        .sleep_i(sleep_i),
        .rc_clk_i(rc_clk_i),
        .tad_tick_o(tad_tick)
    );

    adcs_sar #(
        .WIDTH(RES_W)
    ) u_sar (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(start),
        .abort_i(abort),
        .tad_tick_i(tad_tick),
        .cmp_i(cmp_i),
        .busy_o(busy),
        .code_o(dac_code_o),
        .done_o(done)
    );

    // ****************************************************************
    // port pin configuration
    // ****************************************************************

    // reset value 0000 already means all analog, so reset forces analog
    // analog pin masks
    assign pcfg = cfg_q[`ADCS_CFG_PCFG_HI:`ADCS_CFG_PCFG_LO];

    always @*
    begin
        vref_pos_ext_o = 1'b0;
        vref_neg_ext_o = 1'b0;
        case (pcfg)
            4'b0000: analog_pin_o = 8'hff;
            4'b0001:
            begin
                analog_pin_o = 8'hff;
                vref_pos_ext_o = 1'b1;
            end
            4'b0010: analog_pin_o = 8'h1f;
            4'b0011:
            begin
                analog_pin_o = 8'h1f;
                vref_pos_ext_o = 1'b1;
            end
            4'b0100: analog_pin_o = 8'h0b;
            4'b0101:
            begin
                analog_pin_o = 8'h0b;
                vref_pos_ext_o = 1'b1;
            end
            4'b0110: analog_pin_o = 8'h00;
            4'b0111: analog_pin_o = 8'h00;
            4'b1000:
            begin
                analog_pin_o = 8'hff;
                vref_pos_ext_o = 1'b1;
                vref_neg_ext_o = 1'b1;
            end
            4'b1001: analog_pin_o = 8'h3f;
            4'b1010:
            begin
                analog_pin_o = 8'h3f;
                vref_pos_ext_o = 1'b1;
            end
            4'b1011:
            begin
                analog_pin_o = 8'h3f;
                vref_pos_ext_o = 1'b1;
                vref_neg_ext_o = 1'b1;
            end
            4'b1100:
            begin
                analog_pin_o = 8'h1f;
                vref_pos_ext_o = 1'b1;
                vref_neg_ext_o = 1'b1;
            end
            4'b1101:
            begin
                analog_pin_o = 8'h0f;
                vref_pos_ext_o = 1'b1;
                vref_neg_ext_o = 1'b1;
            end
            4'b1110: analog_pin_o = 8'h01;
            4'b1111:
            begin
                analog_pin_o = 8'h0d;
                vref_pos_ext_o = 1'b1;
                vref_neg_ext_o = 1'b1;
            end
            default: analog_pin_o = 8'hff;
        endcase
    end

endmodule

/* File: tb/adcs_afe_model.sv */
// analog front end model: channel inputs, hold capacitor, comparator, rc osc
// assumes the bench loads vin[] before each conversion starts
`timescale 1ns/1ps

module adcs_afe_model #(
    parameter RC_HALF_NS = 37 // rc half period, unrelated to clk_i
) (
    input logic clk_i,            // system clock
    input logic power_on_i,       // core powered
    input logic hold_connect_i,   // hold capacitor on pin
    input logic [2:0] chan_sel_i, // selected input
    input logic [9:0] dac_code_i, // trial code
    output logic cmp_o,           // input at or above trial
    output logic rc_clk_o         // internal rc clock
);
    logic [9:0] vin [0:7];
    logic [9:0] held_q = 10'h000;
    logic junk_q = 1'b0;

    initial
    begin
        foreach (vin[i])
            vin[i] = 10'h000;
        rc_clk_o = 1'b0;
    end

    always @(posedge clk_i)
    begin
        junk_q <= ~junk_q;
        if (hold_connect_i)
            held_q <= vin[chan_sel_i];
    end

    assign cmp_o = power_on_i ? (held_q >= dac_code_i) : junk_q;

    always #(RC_HALF_NS) rc_clk_o = ~rc_clk_o;
endmodule

/* File: tb/adcs_top_properties.sv */
// port checks for the converter control sequencer
// assumes one clock domain and the async high reset of adcs_top
`timescale 1ns/1ps

module adcs_top_properties (
    input logic clk_i,            // clock
    input logic reset_i,          // reset
    input logic psel_i,           // apb select
    input logic penable_i,        // apb enable
    input logic pwrite_i,         // apb write
    input logic [7:0] paddr_i,    // apb address
    input logic [31:0] pwdata_i,  // apb write data
    input logic [31:0] prdata_o,  // apb read data
    input logic power_on_o,       // core powered
    input logic [2:0] chan_sel_o, // channel
    input logic hold_connect_o,   // hold on pin
    input logic [7:0] analog_pin_o, // analog pins
    input logic vref_pos_ext_o,   // positive ref
    input logic vref_neg_ext_o,   // negative ref
    input logic conv_busy_o,      // busy
    input logic conv_flag_o       // done flag
);
    // {pos ref, neg ref, pin mask} per port code, ref pins count as analog
    localparam logic [9:0] PIN_MAP [0:15] = '{10'h0ff, 10'h2ff, 10'h01f, 10'h21f, 10'h00b, 10'h20b,
        10'h000, 10'h000, 10'h3ff, 10'h03f, 10'h23f, 10'h33f, 10'h31f, 10'h30f, 10'h001, 10'h30d};
    logic [3:0] pcfg_q;
    logic fmt_q;
    logic [9:0] busy_n_q;
    wire wr_en = psel_i && penable_i && pwrite_i;
    wire rd_en = psel_i && penable_i && !pwrite_i;
    wire [2:0] wchan = pwdata_i[5:3];

    // shadow of port code and format, taken at the access edge
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pcfg_q <= 4'h0;
            fmt_q <= 1'b0;
        end
        else if (wr_en && paddr_i == 8'h04)
        begin
            pcfg_q <= pwdata_i[3:0];
            fmt_q <= pwdata_i[7];
        end
    end

    // busy length in clocks, saturating so long stalls cannot wrap
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i || !conv_busy_o)
            busy_n_q <= 10'h000;
        else if (busy_n_q != 10'h3ff)
            busy_n_q <= busy_n_q + 10'h001;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_reset_pins_analog:
    assert property ($fell(reset_i) |-> analog_pin_o == 8'hff) else $error("pins not analog after reset");
    a_pin_decode:
    assert property ({vref_pos_ext_o, vref_neg_ext_o, analog_pin_o} == PIN_MAP[pcfg_q])
        else $error("pin setup differs from port code");
    a_go_starts:
    assert property (wr_en && paddr_i == 8'h00 && pwdata_i[2] && pwdata_i[0] && !conv_busy_o
        |=> ##[0:1] (conv_busy_o && !hold_connect_o)) else $error("start not taken");
    a_go_unpowered:
    assert property (wr_en && paddr_i == 8'h00 && pwdata_i[2] && !pwdata_i[0]
        |-> ##2 (!conv_busy_o) [*3]) else $error("start while powered off");
    a_off_idle:
    assert property ((!power_on_o) [*2] |-> !conv_busy_o && !hold_connect_o) else $error("core active while off");
    a_chan_route:
    assert property (wr_en && paddr_i == 8'h00 && !conv_busy_o |=> chan_sel_o == $past(wchan))
        else $error("channel not routed");
    a_done_flag:
    assert property ($fell(conv_busy_o) && power_on_o |-> ##[0:3] conv_flag_o) else $error("no flag at done");
    a_busy_min:
    assert property ($fell(conv_busy_o) && power_on_o |-> busy_n_q >= 10'd20) else $error("conversion too short");
    a_rsvd_zero:
    assert property (rd_en && (paddr_i == 8'h00 || paddr_i == 8'h04) |-> prdata_o[31:8] == 24'h0
        && (paddr_i == 8'h00 ? !prdata_o[1] : prdata_o[5:4] == 2'b00)) else $error("reserved bit set");
    a_right_just:
    assert property (rd_en && fmt_q && paddr_i == 8'h08 |-> prdata_o[7:2] == 6'h00) else $error("high not right");
    a_left_just:
    assert property (rd_en && !fmt_q && paddr_i == 8'h0c |-> prdata_o[5:0] == 6'h00) else $error("low not left");
endmodule

bind adcs_top adcs_top_properties u_adcs_top_properties (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .power_on_o, .chan_sel_o, .hold_connect_o, .analog_pin_o,
    .vref_pos_ext_o, .vref_neg_ext_o, .conv_busy_o, .conv_flag_o);

/* File: tb/testbench.sv */
// self-checking bench: apb driver notes expected reads, monitor compares
// assumes the front end model drives the comparator and rc clock
`timescale 1ns/1ps

module testbench;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic sleep_i = 1'b0;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, rc_clk_i, cmp_i, power_on_o, hold_connect_o;
    wire vref_pos_ext_o, vref_neg_ext_o, conv_busy_o, conv_flag_o;
    wire [2:0] chan_sel_o;
    wire [9:0] dac_code_o;
    wire [7:0] analog_pin_o;
    logic [64:0] exp_q [$];
    int bad_count = 0;
    int compares = 0;

    adcs_top u_adcs_top (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .sleep_i, .rc_clk_i, .cmp_i, .power_on_o, .chan_sel_o, .hold_connect_o,
        .dac_code_o, .analog_pin_o, .vref_pos_ext_o, .vref_neg_ext_o, .conv_busy_o, .conv_flag_o);
    adcs_afe_model u_adcs_afe_model (.clk_i, .power_on_i(power_on_o), .hold_connect_i(hold_connect_o),
        .chan_sel_i(chan_sel_o), .dac_code_i(dac_code_o), .cmp_o(cmp_i), .rc_clk_o(rc_clk_i));

    always #2.5 clk_i = ~clk_i;

    task automatic end_of_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    // note is {error, read mask, read value}
    task automatic cmp_bus(input logic [64:0] note);
        compares++;
        if (((prdata_o & note[63:32]) !== note[31:0]) || (pslverr_o !== note[64]))
        begin
            bad_count++;
            $display("mismatch at %0t: bus %h err %b expected %h", $time, prdata_o, pslverr_o, note);
        end
    endtask

    // the result shows at the access edge, so take the oldest note then
    always @(posedge clk_i)
    begin
        if (psel_i && penable_i && pready_o === 1'b1)
            cmp_bus(exp_q.pop_front());
    end

    // idle edge at the end keeps back to back calls from double driving
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [64:0] note);
        exp_q.push_back(note);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1)
            @(posedge clk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {1'b0, 64'h0});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, 32'hffffffff, e});
    endtask

    // one conversion; input flips after start, held value must win
    task automatic conv(input logic [2:0] sel, input logic [2:0] ch, input logic fmt, input logic [9:0] v);
        real t0;
        int d;
        int tol;
        tol = (sel[1:0] == 2'b11) ? 20 : 6;
        d = (sel[1:0] == 2'b11) ? 172 : 12 * ((sel[2] ? 4 : 2) << (2 * sel[1:0]));
        u_adcs_afe_model.vin[ch] = v;
        wr(8'h04, {24'h0, fmt, sel[2], 6'h00});
        wr(8'h00, {24'h0, sel[1:0], ch, 3'b001});
        wr(8'h00, {24'h0, sel[1:0], ch, 3'b101});
        t0 = $realtime;
        u_adcs_afe_model.vin[ch] = ~v;
        rd(8'h00, {24'h0, sel[1:0], ch, 3'b101});
        do
            @(negedge clk_i);
        while (conv_flag_o !== 1'b1);
        d = int'(($realtime - t0) / 5.0) - d;
        cmp_val({31'h0, d >= -tol && d <= tol}, 32'h1);
        cmp_val({31'h0, conv_busy_o}, 32'h0);
        @(posedge clk_i);
        rd(8'h00, {24'h0, sel[1:0], ch, 3'b001});
        rd(8'h08, fmt ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
        rd(8'h0c, fmt ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00});
        rd(8'h10, 32'h1);
        wr(8'h10, 32'h1);
        rd(8'h10, 32'h0);
        repeat (130) @(posedge clk_i);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        end_of_test;
    end

    initial
    begin
        int k;
        logic [9:0] v;
        k = $urandom(32'h880e);
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h10, 32'h0);
        cmp_val({24'h0, analog_pin_o}, 32'hff);
        wr(8'h00, 32'hfa);
        rd(8'h00, 32'hf8);
        wr(8'h04, 32'hff);
        rd(8'h04, 32'hcf);
        apb(1'b1, 8'h14, 32'hff, {1'b1, 64'h0});
        apb(1'b0, 8'h14, 32'h0, {1'b1, 32'hffffffff, 32'h0});
        // every port code; full decode is watched by the checker
        for (k = 0; k < 16; k++)
        begin
            wr(8'h04, 32'(k));
            cmp_val({31'h0, analog_pin_o[0]}, {31'h0, k[3:1] != 3'b011});
        end
        for (k = 0; k < 8; k++)
        begin
            v = (k == 0) ? 10'h3ff : 10'($urandom);
            conv(k[2:0], 3'($urandom), 1'($urandom), v);
        end
        sleep_i <= 1'b1;
        conv(3'b011, 3'd5, 1'b1, 10'h155);
        // divider clock stalls while asleep
        wr(8'h04, 32'h40);
        wr(8'h00, 32'h85);
        repeat (100) @(negedge clk_i);
        cmp_val({31'h0, conv_busy_o}, 32'h1);
        @(posedge clk_i);
        sleep_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        wr(8'h00, 32'h80);
        repeat (2) @(negedge clk_i);
        cmp_val({30'h0, conv_flag_o, conv_busy_o}, 32'h0);
        @(posedge clk_i);
        wr(8'h00, 32'h04);
        rd(8'h10, 32'h0);
        // reset in mid conversion
        wr(8'h00, 32'h85);
        repeat (30) @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h00, 32'h0);
        rd(8'h10, 32'h0);
        cmp_val({24'h0, analog_pin_o}, 32'hff);
        rd(8'h08, 32'h55);
        end_of_test;
    end
endmodule
